/* split_power_pkg.sv */
// Constants shared by the split power reset and isolation block
`default_nettype none
package split_power_pkg;
  localparam int unsigned CLK_HZ           = 250_000_000;
  localparam int unsigned ADDR_W           = 4;
  localparam int unsigned DATA_W           = 32;
  localparam int unsigned BUS_W            = 8;
  localparam int unsigned SYNC_STAGES      = 2;
  // Register word offsets (byte address = 4 x index)
  localparam logic [3:0]  CTRL_IDX         = 4'h0;
  localparam logic [3:0]  STAT_IDX         = 4'h1;
  localparam logic [3:0]  IRQ_STAT_IDX     = 4'h2;
  localparam logic [3:0]  IRQ_MASK_IDX     = 4'h3;
  // Control fields
  localparam int unsigned CTRL_DUAL_BIT    = 0;
  localparam int unsigned CTRL_WAKE_BIT    = 1;
  localparam logic [1:0]  CTRL_RESET_VAL   = 2'h0;
  // Event bits
  localparam int unsigned EV_OFF_BIT       = 0;
  localparam int unsigned EV_ON_BIT        = 1;
  localparam int unsigned EV_WAKE_BIT      = 2;
  localparam int unsigned EV_W             = 3;
  localparam logic [2:0]  EV_RESET_VAL     = 3'h0;
  localparam logic [31:0] DATA_ZERO        = 32'h0000_0000;
  typedef enum logic [1:0] {ST_OFF, ST_ON, ST_SWITCHOFF} pwr_state_t;
endpackage : split_power_pkg
`default_nettype wire

/* sync_two_ff.sv */
// Two flip-flop level synchroniser with constant reset value
`default_nettype none
module sync_two_ff #(
  parameter int unsigned W         = 1,
  parameter logic        RESET_VAL = 1'b0
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] async_i,
  output var  logic [W-1:0] sync_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_r <= {W{RESET_VAL}};
      sync_o <= {W{RESET_VAL}};
    end else begin
      meta_r <= meta_nxt;
      sync_o <= sync_nxt;
    end
  end
endmodule // sync_two_ff
`default_nettype wire

/* shifter_receiver_cell.sv */
// Registered boundary receiver cell bank: zero while shifter is off
`default_nettype none
module shifter_receiver_cell #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic         shifter_off_i,
  input  wire logic [W-1:0] send_i,
  output var  logic [W-1:0] recv_o
);
  logic [W-1:0] recv_nxt;

  genvar g;
  generate
    for (g = 0; g < int'(W); g++) begin : g_cell
      always_comb begin
        recv_nxt[g] = shifter_off_i ? 1'b0 : send_i[g]; // [RL1]
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      recv_o <= '0;
    end else begin
      recv_o <= recv_nxt;
    end
  end

  a_cell_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL1]
    shifter_off_i |=> recv_o == '0) else $error("cell not zero while off");
  a_cell_pass: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL1]
    !shifter_off_i |=> recv_o == $past(send_i)) else $error("cell not passing");
endmodule // shifter_receiver_cell
`default_nettype wire

/* split_power_reset_isolation.sv */
// Always-on split power reset merge, isolation and wake request logic
// Summary of operation
// RL1: Receiver cells output zero while shifter off, else pass sender value.
// RL2: Peripheral bus toward backup masked except during clock module accesses; the code also masks it while isolated.
// RL3: Backup outputs feeding the core forced to zero while isolated.
// RL4: Dual-domain off or boot select high: core reset follows supply reset only.
// RL5: Otherwise core reset when supply reset or system-on request low.
// RL6: Clock module state reset only by the supply-on reset.
// RL7: System-on request resets only core logic, never the clock module.
// RL8: Power manager removes core power while system-on request is low.
// RL9: In off mode request, wake and supply reset stay functional.
// RL10: Wake request combines sources gated by dual enable and alarm.
// RL11: In off mode general wake source forced to zero.
// RL12: In on state either alarm or general source raises wake.
// RL13: Core-side general wake source tied to zero.
// RL14: Core held in reset until system-on request goes high.
// RL15: On switch-off stop core slow clock and assert core reset.
// RL16: Isolation asserted on switch-off before core supply removal.
// RL17: External alarm source is inverse of on-chip alarm line.
// RL18: Core reset merged glitch-free; overlap never deasserts spuriously.
`default_nettype none
module split_power_reset_isolation
  import split_power_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  input  wire logic              system_on_request_i,
  input  wire logic              boot_reset_sel_i,
  input  wire logic              alarm_irq_n_i,
  input  wire logic              slow_clk_i,
  input  wire logic              bus_sel_i,
  input  wire logic [BUS_W-1:0]  bus_data_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [BUS_W-1:0]  backup_data_i,
  output var  logic [DATA_W-1:0] reg_rdata_o,
  output var  logic              core_domain_reset_n_o,
  output var  logic              backup_isolate_o,
  output var  logic              core_slow_clk_en_o,
  output var  logic              external_alarm_source_o,
  output var  logic              wake_request_o,
  output var  logic [BUS_W-1:0]  backup_bus_o,
  output var  logic [BUS_W-1:0]  core_data_o,
  output var  logic              irq_o
);
  // arst_n_i is the supply-on reset; it alone clears this block [RL6] [RL7]
  logic              son_s;
  logic              alarm_n_s;
  logic              boot_s;
  logic [1:0]        ctrl_r;
  logic [1:0]        ctrl_nxt;
  logic [EV_W-1:0]   ev_r;
  logic [EV_W-1:0]   ev_nxt;
  logic [EV_W-1:0]   mask_r;
  logic [EV_W-1:0]   mask_nxt;
  logic [EV_W-1:0]   ev_set;
  logic [DATA_W-1:0] rdata_nxt;
  pwr_state_t        st_r;
  pwr_state_t        st_nxt;
  logic              core_rst_n_nxt;
  logic              iso_nxt;
  logic              clk_en_nxt;
  logic              ext_alarm_nxt;
  logic              wake_nxt;
  logic [BUS_W-1:0]  bus_nxt;
  logic              irq_nxt;
  logic              son_d_r;
  logic              wake_d_r;
  logic              dual_en;
  logic              merge_mode;
  logic              general_wake;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] idx);
    return a == idx;
  endfunction

  sync_two_ff #(.W(1), .RESET_VAL(1'b0)) u_sync_son (
    .clk_i   (clk_i),
    .arst_n_i(arst_n_i),
    .async_i (system_on_request_i),
    .sync_o  (son_s)
  );
  sync_two_ff #(.W(1), .RESET_VAL(1'b1)) u_sync_alarm (
    .clk_i   (clk_i),
    .arst_n_i(arst_n_i),
    .async_i (alarm_irq_n_i),
    .sync_o  (alarm_n_s)
  );
  sync_two_ff #(.W(1), .RESET_VAL(1'b0)) u_sync_boot (
    .clk_i   (clk_i),
    .arst_n_i(arst_n_i),
    .async_i (boot_reset_sel_i),
    .sync_o  (boot_s)
  );

  // Boundary cells toward the core, blocked while isolated
  shifter_receiver_cell #(.W(BUS_W)) u_rx_cells (
    .clk_i        (clk_i),
    .arst_n_i     (arst_n_i),
    .shifter_off_i(iso_nxt),
    .send_i       (backup_data_i),
    .recv_o       (core_data_o)
  ); // [RL3]

  assign dual_en      = ctrl_r[CTRL_DUAL_BIT];
  assign merge_mode   = dual_en && !boot_s;
  // Core-side general source is tied low; only software test bit feeds it in ON
  assign general_wake = (st_r == ST_ON) ? ctrl_r[CTRL_WAKE_BIT] : 1'b0; // [RL11] [RL13]

  // Power state: the request is the only thing that moves it
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_OFF: begin
        if (son_s) begin
          st_nxt = ST_ON; // [RL14]
        end
      end
      ST_ON: begin
        if (!son_s) begin
          st_nxt = ST_SWITCHOFF; // [RL15]
        end
      end
      ST_SWITCHOFF: begin
        st_nxt = son_s ? ST_ON : ST_OFF;
      end
      default: begin
        st_nxt = ST_OFF;
      end
    endcase
  end

  // Outputs, all registered; reset merge uses only synchronised levels,
  // so the two sources overlapping cannot produce a release pulse
  always_comb begin
    if (merge_mode) begin
      core_rst_n_nxt = son_s && (st_nxt == ST_ON); // [RL5] [RL14] [RL15] [RL18]
      iso_nxt        = (st_nxt != ST_ON);          // [RL16] [RL3]
      clk_en_nxt     = (st_nxt == ST_ON);          // [RL15]
    end else begin
      core_rst_n_nxt = 1'b1;                       // [RL4] supply reset alone
      iso_nxt        = 1'b0;
      clk_en_nxt     = 1'b1;
    end
    ext_alarm_nxt = !alarm_n_s;                                      // [RL17]
    wake_nxt      = dual_en && (ext_alarm_nxt || general_wake);      // [RL10] [RL12] [RL9]
    bus_nxt       = (bus_sel_i && !iso_nxt) ? bus_data_i : '0;      // [RL2]
    irq_nxt       = |(ev_nxt & mask_nxt);
  end

  // Registers: sticky events set wins over write-one clear
  always_comb begin
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    ev_set   = '0;
    ev_set[EV_OFF_BIT]  = son_d_r && !son_s;
    ev_set[EV_ON_BIT]   = !son_d_r && son_s;
    ev_set[EV_WAKE_BIT] = wake_nxt && !wake_d_r;
    ev_nxt   = ev_r;
    if (reg_wr_i && hit(reg_addr_i, CTRL_IDX)) begin
      ctrl_nxt = reg_wdata_i[1:0];
    end
    if (reg_wr_i && hit(reg_addr_i, IRQ_MASK_IDX)) begin
      mask_nxt = reg_wdata_i[EV_W-1:0];
    end
    if (reg_wr_i && hit(reg_addr_i, IRQ_STAT_IDX)) begin
      ev_nxt = ev_nxt & ~reg_wdata_i[EV_W-1:0];
    end
    ev_nxt    = ev_nxt | ev_set;
    rdata_nxt = DATA_ZERO;
    if (reg_rd_i) begin
      case (reg_addr_i)
        CTRL_IDX:     rdata_nxt = {30'h0000_0000, ctrl_r};
        STAT_IDX:     rdata_nxt = {26'h000_0000, st_r, backup_isolate_o,
                                   core_domain_reset_n_o, wake_request_o, son_s};
        IRQ_STAT_IDX: rdata_nxt = {29'h0000_0000, ev_r};
        IRQ_MASK_IDX: rdata_nxt = {29'h0000_0000, mask_r};
        default:      rdata_nxt = DATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r                    <= ST_OFF;
      ctrl_r                  <= CTRL_RESET_VAL;
      ev_r                    <= EV_RESET_VAL;
      mask_r                  <= EV_RESET_VAL;
      son_d_r                 <= 1'b0;
      wake_d_r                <= 1'b0;
      reg_rdata_o             <= DATA_ZERO;
      core_domain_reset_n_o   <= 1'b0; // [RL4] [RL6]
      backup_isolate_o        <= 1'b1;
      core_slow_clk_en_o      <= 1'b0;
      external_alarm_source_o <= 1'b0;
      wake_request_o          <= 1'b0;
      backup_bus_o            <= '0;
      irq_o                   <= 1'b0;
    end else begin
      st_r                    <= st_nxt;
      ctrl_r                  <= ctrl_nxt;
      ev_r                    <= ev_nxt;
      mask_r                  <= mask_nxt;
      son_d_r                 <= son_s;
      wake_d_r                <= wake_nxt;
      reg_rdata_o             <= rdata_nxt;
      core_domain_reset_n_o   <= core_rst_n_nxt;
      backup_isolate_o        <= iso_nxt;
      core_slow_clk_en_o      <= clk_en_nxt;
      external_alarm_source_o <= ext_alarm_nxt;
      wake_request_o          <= wake_nxt;
      backup_bus_o            <= bus_nxt;
      irq_o                   <= irq_nxt;
    end
  end

  // Checks
  // Both power edges are one synchronised level seen in a given state
  sequence s_switch_off;
    merge_mode && (st_r == ST_ON) && !son_s;
  endsequence

  sequence s_switch_on;
    merge_mode && (st_r != ST_ON) && son_s;
  endsequence

  sequence s_still_off;
    merge_mode && !son_s;
  endsequence

  // Reset merge
  a_legacy_reset: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL4]
    !merge_mode |=> core_domain_reset_n_o)
    else $error("reset not supply only");
  a_legacy_open: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL4]
    !merge_mode |=> (!backup_isolate_o && core_slow_clk_en_o))
    else $error("legacy mode isolated");
  a_merge_reset: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL5]
    (merge_mode && !son_s) |=> !core_domain_reset_n_o)
    else $error("core not reset");
  a_clean_release: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL18]
    (core_domain_reset_n_o && $past(merge_mode)) |-> $past(son_s))
    else $error("core released without request");

  // Switch-off and switch-on
  a_off_sequence: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL15]
    s_switch_off |=> (!core_slow_clk_en_o && !core_domain_reset_n_o && backup_isolate_o))
    else $error("switch-off incomplete");
  a_off_held: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL15] [RL16]
    s_switch_off ##1 s_still_off |=> (!core_domain_reset_n_o && backup_isolate_o))
    else $error("off state not held");
  a_switch_on: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL14]
    s_switch_on |=> (core_domain_reset_n_o && !backup_isolate_o && core_slow_clk_en_o))
    else $error("switch-on incomplete");
  a_off_leaves: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL15]
    (st_r == ST_SWITCHOFF) |=> (st_r != ST_SWITCHOFF))
    else $error("stuck in switch-off");
  a_iso_before: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL16]
    (merge_mode && !core_domain_reset_n_o && $past(merge_mode)) |-> backup_isolate_o)
    else $error("reset without isolation");
  a_hold_reset: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL14]
    (merge_mode && st_r == ST_OFF && !son_s) |=> !core_domain_reset_n_o)
    else $error("core released early");

  // Bus and boundary
  a_bus_masked: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL2]
    !bus_sel_i |=> backup_bus_o == '0)
    else $error("bus not masked");
  a_bus_pass: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL2]
    (bus_sel_i && !iso_nxt) |=> backup_bus_o == $past(bus_data_i))
    else $error("bus access not passed");
  a_bus_iso: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL3]
    iso_nxt |=> backup_bus_o == '0)
    else $error("bus driven while isolated");
  a_core_data_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL3]
    iso_nxt |=> core_data_o == '0)
    else $error("core data driven while isolated");

  // Wake request
  a_alarm_invert: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL17]
    external_alarm_source_o == !$past(alarm_n_s))
    else $error("alarm not inverted");
  a_wake_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL10]
    wake_request_o |-> $past(dual_en))
    else $error("wake without enable");
  a_wake_alarm: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL9] [RL10]
    (dual_en && !alarm_n_s) |=> wake_request_o)
    else $error("alarm wake lost");
  a_wake_on: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL12]
    (dual_en && st_r == ST_ON && ctrl_r[CTRL_WAKE_BIT]) |=> wake_request_o)
    else $error("general wake lost in on");
  a_off_wake: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL11]
    (st_r != ST_ON && !ext_alarm_nxt) |=> !wake_request_o)
    else $error("general wake in off");
  a_general_tied: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL13]
    (st_r != ST_ON) |-> !general_wake)
    else $error("general wake not tied low");

  // Registers and interrupt; control must survive any number of power cycles
  a_ctrl_kept: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL7] [RL6]
    !(reg_wr_i && hit(reg_addr_i, CTRL_IDX)) |=> ctrl_r == $past(ctrl_r))
    else $error("control lost without write");
  a_event_sticky: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (ev_set != '0) |=> (ev_r & $past(ev_set)) == $past(ev_set))
    else $error("event lost");
  a_irq_level: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    irq_o == |(ev_r & mask_r))
    else $error("interrupt level wrong");
endmodule // split_power_reset_isolation
`default_nettype wire

/* power_companion_model.sv */
// Behavioural power companion that drives the system-on request
`default_nettype none
module power_companion_model #(
  parameter int unsigned LAG = 3
) (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic on_cmd_i,
  input  wire logic off_cmd_i,
  input  wire logic wake_request_i,
  output var  logic system_on_request_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic           on_r;
  logic [LAG-1:0] dly_r;
  // Off command wins, so a stuck wake line cannot keep the core powered
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      on_r  <= 1'b0;
      dly_r <= '0;
    end else begin
      on_r  <= off_cmd_i ? 1'b0 : (on_r | on_cmd_i | wake_request_i);
      dly_r <= {dly_r[LAG-2:0], on_r};
    end
  end
  // Core supply is cut while the request stays low
  assign system_on_request_o = dly_r[LAG-1];
endmodule // power_companion_model
`default_nettype wire

/* split_power_reset_isolation_test.sv */
// Self-checking bench for the split power reset and isolation block
`default_nettype none
module split_power_reset_isolation_test
  import split_power_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_i = 1'b0, arst_n_i = 1'b0, on_cmd = 1'b0, off_cmd = 1'b1;
  logic              boot = 1'b0, alarm_n = 1'b1, bus_sel = 1'b0, wr = 1'b0, rd = 1'b0;
  logic              son, core_rst_n, iso, clk_en, ext_al, wake, irq;
  logic [BUS_W-1:0]  bus_d = 8'h00, bk_d = 8'h00, bk_bus, core_d;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [DATA_W-1:0] wdata = 32'h0000_0000, rdata, rv;
  int                num_errors = 0, checks_done = 0, seed = 32'hbc63_1d6f;
  string             nm [6] = '{"core_reset", "isolate", "clk_en", "ext_alarm", "wake", "irq"};

  split_power_reset_isolation split_power_reset_isolation_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .system_on_request_i(son), .boot_reset_sel_i(boot),
    .alarm_irq_n_i(alarm_n), .slow_clk_i(1'b0), .bus_sel_i(bus_sel), .bus_data_i(bus_d),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .backup_data_i(bk_d), .reg_rdata_o(rdata), .core_domain_reset_n_o(core_rst_n),
    .backup_isolate_o(iso), .core_slow_clk_en_o(clk_en), .external_alarm_source_o(ext_al),
    .wake_request_o(wake), .backup_bus_o(bk_bus), .core_data_o(core_d), .irq_o(irq));
  power_companion_model #(.LAG(3)) power_companion_model_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .on_cmd_i(on_cmd), .off_cmd_i(off_cmd),
    .wake_request_i(wake), .system_on_request_o(son));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic complete_run;
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [DATA_W-1:0] exp,
                     input logic [DATA_W-1:0] got);
    checks_done++;
    if (exp !== got) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return core_rst_n;
      1: return iso;
      2: return clk_en;
      3: return ext_al;
      4: return wake;
      default: return irq;
    endcase
  endfunction

  // Bounded wait: latencies through the synchronisers are only approximate
  task automatic await(input int s, input logic v, input int n);
    // Step off the edge first, so a value launched there has settled
    #1;
    for (int i = 0; i < n && pick(s) !== v; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk(nm[s], {31'h0, v}, {31'h0, pick(s)});
  endtask

  task automatic hold(input int s, input logic v, input int n);
    repeat (n) begin
      @(posedge clk_i);
      #1 chk(nm[s], {31'h0, v}, {31'h0, pick(s)});
    end
  endtask

  task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                      input logic [DATA_W-1:0] m);
    @(posedge clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 chk("reg_rdata", exp, rdata & m);
  endtask

  task automatic datapath(input int n, input logic isolated);
    repeat (n) begin
      @(posedge clk_i);
      rv = $random(seed);
      bus_sel <= rv[0];
      bus_d <= rv[15:8];
      bk_d <= rv[23:16];
      @(posedge clk_i);
      #1 chk("backup_bus", (bus_sel && !isolated) ? bus_d : 8'h00, bk_bus);
      chk("core_data", isolated ? 8'h00 : bk_d, core_d);
    end
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    await(0, 1'b1, 4);
    rreg(CTRL_IDX, {30'h0, CTRL_RESET_VAL}, 32'hFFFF_FFFF);
    rreg(4'h7, DATA_ZERO, 32'hFFFF_FFFF);
    hold(0, 1'b1, 6);
    @(posedge clk_i);
    boot <= 1'b1;
    wreg(CTRL_IDX, 32'h0000_0001);
    hold(0, 1'b1, 8);
    @(posedge clk_i);
    boot <= 1'b0;
    await(0, 1'b0, 8);
    await(1, 1'b1, 2);
    await(2, 1'b0, 2);
    datapath(20, 1'b1);
    @(posedge clk_i);
    off_cmd <= 1'b0;
    on_cmd <= 1'b1;
    await(0, 1'b1, 16);
    await(1, 1'b0, 2);
    await(2, 1'b1, 2);
    datapath(40, 1'b0);
    wreg(CTRL_IDX, 32'h0000_0003);
    await(4, 1'b1, 6);
    rreg(STAT_IDX, 32'h0000_0017, 32'h0000_003F);
    @(posedge clk_i);
    off_cmd <= 1'b1;
    on_cmd <= 1'b0;
    await(0, 1'b0, 16);
    await(4, 1'b0, 6);
    rreg(CTRL_IDX, 32'h0000_0003, 32'hFFFF_FFFF);
    @(posedge clk_i);
    off_cmd <= 1'b0;
    hold(4, 1'b0, 10);
    @(posedge clk_i);
    alarm_n <= 1'b0;
    await(3, 1'b1, 5);
    await(4, 1'b1, 3);
    await(0, 1'b1, 20);
    wreg(CTRL_IDX, 32'h0000_0000);
    hold(4, 1'b0, 6);
    @(posedge clk_i);
    alarm_n <= 1'b1;
    await(3, 1'b0, 5);
    rreg(IRQ_STAT_IDX, 32'h0000_0007, 32'h0000_0007);
    hold(5, 1'b0, 2);
    wreg(IRQ_MASK_IDX, 32'h0000_0007);
    await(5, 1'b1, 3);
    wreg(IRQ_STAT_IDX, 32'h0000_0007);
    await(5, 1'b0, 3);
    rreg(IRQ_STAT_IDX, DATA_ZERO, 32'hFFFF_FFFF);
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    #1 chk("core_reset", 32'h0, {31'h0, core_rst_n});
    @(posedge clk_i);
    arst_n_i <= 1'b1;
    rreg(CTRL_IDX, DATA_ZERO, 32'hFFFF_FFFF);
    complete_run();
  end

  initial begin
    #40000;
    num_errors++;
    complete_run();
  end
endmodule // split_power_reset_isolation_test
`default_nettype wire
